//--- pll_unlock_status_logic_tb_top.sv
`timescale 1ns/1ns
`include "plldet_regs.vh"

// ----------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------
module pll_unlock_status_logic_tb_top;
  localparam int REF = 20;
  localparam int GATE = 50;
  typedef struct {
    logic [23:0] cfg;
    int          fp;
    logic        port;
    logic        pin;
    logic        both;
  } pusl_row_t;

  logic        aclk, aresetn, clk_en, fp_in, if_count_input, port_in;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, d;
  logic [23:0] r;
  logic [1:0]  rs;
  logic        up, dn;
  wire         ser_ce, ser_cl, ser_di, ser_do_out_r, ser_do_oe_r, pump_up_r, pump_dn_r, irq_r;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [15:0] divisor_r;
  wire         do_pin = ser_do_oe_r ? ser_do_out_r : 1'b1;  // Pull-up on the open-drain pin
  int          i, fp_cnt, fp_per, mismatches, cmp_count;
  pusl_row_t   rows[6] = '{'{24'h0407de, 20, 1'b0, 1'b1, 1'b1}, '{24'h051158, 10, 1'b0, 1'b0, 1'b1},
                           '{24'h0e01e6, 20, 1'b1, 1'b1, 1'b0}, '{24'h0f0123, 20, 1'b0, 1'b0, 1'b0},
                           '{24'h01abcd, 20, 1'b0, 1'b1, 1'b1}, '{24'h080055, 20, 1'b0, 1'b0, 1'b1}};

  plldet_top #(.REF_CYC(REF), .GATE_CYC(GATE), .IFW(20)) i_plldet_top (
    .aclk, .aresetn, .clk_en, .ser_ce, .ser_cl, .ser_di, .ser_do_out_r, .ser_do_oe_r,
    .fp_in, .if_count_input, .port_in, .pump_up_r, .pump_dn_r, .divisor_r, .irq_r,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  pusl_ctrl_model #(.REF_NS(REF * 10)) i_pusl_ctrl_model (.do_pin, .ser_ce, .ser_cl, .ser_di);

  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Loop feedback: one pulse every fp_per cycles; IF input toggles freely
  always @(posedge aclk) begin
    fp_cnt <= (fp_cnt >= fp_per - 1) ? 0 : fp_cnt + 1;
    fp_in <= (fp_cnt == 0);
    if_count_input <= ~if_count_input;
  end

  // Compare, report and close
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic hang(input string what);
    mismatches++;
    $display("CHECK FAILED %0t timeout %s", $time, what);
    print_verdict();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Bus master cycles
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] s);
    int k;
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (k = 0; k < 100; k++) begin
        @(posedge aclk);
        if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
        if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid === 1'b1) break;
      end
      if (k == 100) hang("write");
      s = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
    int k;
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (k = 0; k < 100; k++) begin
        @(posedge aclk);
        if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid === 1'b1) break;
      end
      if (k == 100) hang("read");
      v = s_axi_rdata;
      s = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask

  // Main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {aresetn, fp_in, if_count_input, port_in} = 4'h0;
    clk_en = 1'b1;
    fp_cnt = 0;
    fp_per = REF;
    cyc(8);
    aresetn <= 1'b1;
    axi_rd(`PLLD_ADDR_CFG, d, rs);
    chk(d, 32'h0, "cfg reset");
    axi_rd(`PLLD_ADDR_IRQ_EN, d, rs);
    chk(d, 32'h0, "irq enable reset");
    chk(do_pin, 1'b1, "pin idle");
    chk(irq_r, 1'b0, "irq reset");
    axi_rd(8'h1c, d, rs);
    chk(rs, 2'h2, "unmapped read resp");
    chk(d, 32'h0, "unmapped read data");
    axi_wr(8'h1c, 32'hffffffff, rs);
    chk(rs, 2'h2, "unmapped write resp");
    for (i = 0; i < 6; i++) begin
      axi_wr(`PLLD_ADDR_CFG, {8'h00, rows[i].cfg}, rs);
      fp_per <= rows[i].fp;
      port_in <= rows[i].port;
      i_pusl_ctrl_model.settle();
      {up, dn} = 2'b00;
      repeat (2 * REF) begin
        @(posedge aclk);
        up |= pump_up_r;
        dn |= pump_dn_r;
      end
      chk(divisor_r, rows[i].cfg[15:0], "divisor");
      chk(do_pin, rows[i].pin, "data-out level");
      chk(up && dn, rows[i].both, "pump both ways");
    end
    axi_wr(`PLLD_ADDR_CFG, 32'h00180000, rs);
    cyc(GATE + 20);
    chk(do_pin, 1'b1, "count done");
    axi_rd(`PLLD_ADDR_IFCNT, d, rs);
    chk(d, GATE / 2, "if count");
    axi_wr(`PLLD_ADDR_IRQ_EN, 32'h7, rs);
    i_pusl_ctrl_model.xfer(24, 24'h0007de, r);
    chk(r[22:3], GATE / 2, "count shifted out");
    i_pusl_ctrl_model.settle();
    i_pusl_ctrl_model.xfer(24, 24'h001158, r);
    chk(r[23], 1'b0, "flag while locked");
    chk(r[2:0], 3'b000, "word tail");
    chk(divisor_r, 16'h1158, "serial latch");
    @(posedge aclk);
    fp_per <= REF / 2;
    i_pusl_ctrl_model.settle();
    @(posedge aclk);
    fp_per <= REF;
    i_pusl_ctrl_model.settle();
    axi_rd(`PLLD_ADDR_STAT, d, rs);
    chk(d[2:0], 3'b011, "flag after relock");
    chk(irq_r, 1'b1, "irq raised");
    axi_wr(`PLLD_ADDR_IRQ_EN, 32'h0, rs);
    cyc(3);
    chk(irq_r, 1'b0, "irq masked");
    axi_wr(`PLLD_ADDR_IRQ_EN, 32'h7, rs);
    axi_wr(`PLLD_ADDR_IRQ_CLR, 32'h7, rs);
    axi_rd(`PLLD_ADDR_IRQ_STAT, d, rs);
    chk(d, 32'h0, "irq cleared");
    chk(irq_r, 1'b0, "irq low");
    i_pusl_ctrl_model.xfer(24, 24'h001158, r);
    chk(r[23], 1'b1, "first readout");
    axi_rd(`PLLD_ADDR_IRQ_STAT, d, rs);
    chk(d[2:0], 3'b100, "transfer event");
    chk(irq_r, 1'b1, "irq on transfer");
    i_pusl_ctrl_model.settle();
    i_pusl_ctrl_model.xfer(24, 24'h001158, r);
    chk(r[23], 1'b0, "second readout");
    i_pusl_ctrl_model.xfer(8, 24'hff0000, r);
    chk(divisor_r, 16'h1158, "short frame");
    // Clock enable low: the pump-up output must stand still
    clk_en <= 1'b0;
    @(posedge aclk);
    up = pump_up_r;
    dn = 1'b0;
    repeat (2 * REF) begin
      @(posedge aclk);
      dn |= (pump_up_r !== up);
    end
    clk_en <= 1'b1;
    chk(dn, 1'b0, "frozen pump");
    // Reset in mid-run
    aresetn <= 1'b0;
    cyc(2);
    aresetn <= 1'b1;
    axi_rd(`PLLD_ADDR_CFG, d, rs);
    chk(d, 32'h0, "cfg after reset");
    chk(divisor_r, 16'h0000, "divisor after reset");
    print_verdict();
  end
endmodule // pll_unlock_status_logic_tb_top

//--- plldet_regs.vh
`ifndef PLLDET_REGS_VH
`define PLLDET_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PLLD_ADDR_CFG       8'h00
`define PLLD_ADDR_STAT      8'h04
`define PLLD_ADDR_IFCNT     8'h08
`define PLLD_ADDR_IRQ_STAT  8'h0c
`define PLLD_ADDR_IRQ_CLR   8'h10
`define PLLD_ADDR_IRQ_EN    8'h14

// ----------------------------------------------------------------
// Configuration word fields (serial word and CFG register)
// ----------------------------------------------------------------
`define PLLD_CFG_DIV_LSB    0
`define PLLD_CFG_DIV_MSB    15
`define PLLD_CFG_DZ_LO      16
`define PLLD_CFG_DZ_HI      17
`define PLLD_CFG_DOM_LSB    18
`define PLLD_CFG_DOM_MSB    19
`define PLLD_CFG_CTE        20
`define PLLD_CFG_BITS       24
`define PLLD_CFG_RST        24'h000000

// ----------------------------------------------------------------
// Data-out pin modes and dead-zone modes
// ----------------------------------------------------------------
`define PLLD_DOM_SERIAL     2'h0
`define PLLD_DOM_LOCK       2'h1
`define PLLD_DOM_IFDONE     2'h2
`define PLLD_DOM_PORT       2'h3
`define PLLD_DZ_FIRST       2'h0
`define PLLD_DZ_SECOND      2'h1
`define PLLD_DZ_THIRD       2'h2
`define PLLD_DZ_FOURTH      2'h3

// ----------------------------------------------------------------
// Status and interrupt bits
// ----------------------------------------------------------------
`define PLLD_IRQ_UNLOCK     0
`define PLLD_IRQ_IFDONE     1
`define PLLD_IRQ_XFER       2
`define PLLD_IRQ_BITS       3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PLLD_CLK_NS         10
`define PLLD_REF_NS         40000
`define PLLD_REF_CYC        (`PLLD_REF_NS / `PLLD_CLK_NS)
`define PLLD_GATE_NS        8000000
`define PLLD_GATE_CYC       (`PLLD_GATE_NS / `PLLD_CLK_NS)
`define PLLD_MINPW_A_NS     20
`define PLLD_MINPW_A_CYC    (`PLLD_MINPW_A_NS / `PLLD_CLK_NS)
`define PLLD_MINPW_B_NS     10
`define PLLD_MINPW_B_CYC    (`PLLD_MINPW_B_NS / `PLLD_CLK_NS)
`define PLLD_DZ_C_NS        20
`define PLLD_DZ_C_CYC       ((`PLLD_DZ_C_NS + `PLLD_CLK_NS - 1) / `PLLD_CLK_NS)
`define PLLD_DZ_D_NS        40
`define PLLD_DZ_D_CYC       ((`PLLD_DZ_D_NS + `PLLD_CLK_NS - 1) / `PLLD_CLK_NS)

`endif

//--- plldet_sync.v
`timescale 1ns/1ns

// Two-stage synchroniser for pins from outside the aclk domain
module plldet_sync #(
  parameter WIDTH = 1
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             clk_en,
  input  wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // First stage feeds only the second stage
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end else if (clk_en) begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end

  assign dout = sync_r;

endmodule // plldet_sync

//--- plldet_top.v
`timescale 1ns/1ns
`include "plldet_regs.vh"

module plldet_top #(
  parameter REF_CYC  = `PLLD_REF_CYC,
  parameter GATE_CYC = `PLLD_GATE_CYC,
  parameter IFW      = 20
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        clk_en,
  // Serial link pins
  input  wire        ser_ce,
  input  wire        ser_cl,
  input  wire        ser_di,
  output reg         ser_do_out_r,
  output reg         ser_do_oe_r,
  // Loop and counter inputs
  input  wire        fp_in,
  input  wire        if_count_input,
  input  wire        port_in,
  // Loop outputs and interrupt
  output reg         pump_up_r,
  output reg         pump_dn_r,
  output reg  [15:0] divisor_r,
  output reg         irq_r,
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Address decode, shared by read and write paths
  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `PLLD_ADDR_CFG) || (a == `PLLD_ADDR_STAT) ||
               (a == `PLLD_ADDR_IFCNT) || (a == `PLLD_ADDR_IRQ_STAT) ||
               (a == `PLLD_ADDR_IRQ_CLR) || (a == `PLLD_ADDR_IRQ_EN);
    end
  endfunction

  // Byte-lane merge for writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  wire [5:0] pins_s;
  reg  [5:0] pins_d_r;

  plldet_sync #(.WIDTH(6)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clk_en  (clk_en),
    .din     ({port_in, if_count_input, fp_in, ser_di, ser_cl, ser_ce}),
    .dout    (pins_s)
  );

  // Delayed copy of the synchronised pins for edges
  always @(posedge aclk) begin
    if (!aresetn) begin
      pins_d_r <= 6'h00;
    end else if (clk_en) begin
      pins_d_r <= pins_s;
    end
  end

  wire ce_s    = pins_s[0];
  wire cl_rise = pins_s[1] & ~pins_d_r[1];
  wire cl_fall = ~pins_s[1] & pins_d_r[1];
  wire di_s    = pins_s[2];
  wire fp_rise = pins_s[3] & ~pins_d_r[3];
  wire if_rise = pins_s[4] & ~pins_d_r[4];
  wire port_s  = pins_s[5];
  wire ce_rise = ce_s & ~pins_d_r[0];
  wire ce_fall = ~ce_s & pins_d_r[0];

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  reg  [23:0]     cfg_r;
  reg  [23:0]     in_sr_r;
  reg  [4:0]      in_cnt_r;
  reg  [23:0]     out_sr_r;
  reg  [31:0]     ref_cnt_r;
  reg  [1:0]      fp_cnt_r;
  reg             lock_r;
  reg             unlock_flag_r;
  reg             pd_up_r;
  reg             pd_dn_r;
  reg  [3:0]      pw_r;
  reg  [3:0]      corr_r;
  reg  [IFW-1:0]  if_cnt_r;
  reg  [31:0]     gate_r;
  reg             if_run_r;
  reg             if_done_r;
  reg  [`PLLD_IRQ_BITS-1:0] irq_stat_r;
  reg  [`PLLD_IRQ_BITS-1:0] irq_en_r;
  reg             aw_got_r;
  reg             w_got_r;
  reg  [7:0]      awaddr_r;
  reg  [31:0]     wdata_r;
  reg  [3:0]      wstrb_r;

  wire [1:0] dz_sel  = {cfg_r[`PLLD_CFG_DZ_HI], cfg_r[`PLLD_CFG_DZ_LO]};
  wire [1:0] do_mode = cfg_r[`PLLD_CFG_DOM_MSB:`PLLD_CFG_DOM_LSB];
  wire       cte     = cfg_r[`PLLD_CFG_CTE];
  wire       ref_tick = (ref_cnt_r == REF_CYC - 1);
  wire       xfer_end = ce_fall;
  wire       wr_go    = aw_got_r & w_got_r & ~s_axi_bvalid;
  wire       wr_cfg   = wr_go & (awaddr_r == `PLLD_ADDR_CFG);
  wire [31:0] cfg_wr  = merge({8'h00, cfg_r}, wdata_r, wstrb_r);

  // Lock judged from fp edges counted across one whole period
  wire [1:0] fp_total  = (fp_cnt_r == 2'h3) ? 2'h3 : fp_cnt_r + {1'b0, fp_rise};
  wire       lock_now  = (fp_total == 2'h1);
  wire       unlock_ev = ref_tick & ~lock_now;
  wire       ifdone_ev = if_run_r & (gate_r == GATE_CYC - 1);

  // ----------------------------------------------------------------
  // Serial link: shift-in, latch, shift-out
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r    <= `PLLD_CFG_RST;
      in_sr_r  <= 24'h000000;
      in_cnt_r <= 5'h00;
      out_sr_r <= 24'h000000;
    end else if (clk_en) begin
      if (ce_s && cl_rise) begin
        in_sr_r  <= {in_sr_r[22:0], di_s};
        in_cnt_r <= (in_cnt_r == 5'h1f) ? in_cnt_r : in_cnt_r + 5'h01;
      end
      // Flag sits first, then the 20-bit count MSB first
      if (ce_rise) begin
        out_sr_r <= {unlock_flag_r, if_cnt_r, 3'h0};
        in_cnt_r <= 5'h00;
      end else if (ce_s && cl_fall) begin
        out_sr_r <= {out_sr_r[22:0], 1'b0};
      end
      // Serial latch has priority over a bus write
      if (ce_fall && in_cnt_r >= `PLLD_CFG_BITS) begin
        cfg_r <= in_sr_r;
      end else if (wr_cfg) begin
        cfg_r <= cfg_wr[23:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Reference period and lock evaluation
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      ref_cnt_r     <= 32'h00000000;
      fp_cnt_r      <= 2'h0;
      lock_r        <= 1'b0;
      unlock_flag_r <= 1'b0;
      divisor_r     <= 16'h0000;
    end else if (clk_en) begin
      divisor_r <= cfg_r[`PLLD_CFG_DIV_MSB:`PLLD_CFG_DIV_LSB];
      if (ref_tick) begin
        ref_cnt_r <= 32'h00000000;
        fp_cnt_r  <= 2'h0;
        lock_r    <= lock_now;
      end else begin
        ref_cnt_r <= ref_cnt_r + 32'h00000001;
        fp_cnt_r  <= fp_total;
      end
      // Set beats clear when both land together
      if (unlock_ev) begin
        unlock_flag_r <= 1'b1;
      end else if (xfer_end) begin
        unlock_flag_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Phase comparator and charge pump dead-zone control
  // ----------------------------------------------------------------
  // Mode timings held wide, cut to the width counter where used
  localparam [31:0] MINPW_A = `PLLD_MINPW_A_CYC;
  localparam [31:0] MINPW_B = `PLLD_MINPW_B_CYC;
  localparam [31:0] DZ_C    = `PLLD_DZ_C_CYC;
  localparam [31:0] DZ_D    = `PLLD_DZ_D_CYC;

  reg       pump_up_nxt;
  reg       pump_dn_nxt;
  reg [3:0] dz_w;
  reg [3:0] min_w;

  // Select dead zone or minimum correction width per mode
  always @* begin
    dz_w  = 4'h0;
    min_w = 4'h0;
    case (dz_sel)
      `PLLD_DZ_FIRST:  min_w = MINPW_A[3:0];
      `PLLD_DZ_SECOND: min_w = MINPW_B[3:0];
      `PLLD_DZ_THIRD:  dz_w  = DZ_C[3:0];
      `PLLD_DZ_FOURTH: dz_w  = DZ_D[3:0];
      default:         dz_w  = 4'h0;
    endcase
    if (min_w != 4'h0) begin
      pump_up_nxt = pd_up_r | (corr_r != 4'h0);
      pump_dn_nxt = pd_dn_r | (corr_r != 4'h0);
    end else begin
      pump_up_nxt = pd_up_r & (pw_r >= dz_w);
      pump_dn_nxt = pd_dn_r & (pw_r >= dz_w);
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      pd_up_r   <= 1'b0;
      pd_dn_r   <= 1'b0;
      pw_r      <= 4'h0;
      corr_r    <= 4'h0;
      pump_up_r <= 1'b0;
      pump_dn_r <= 1'b0;
    end else if (clk_en) begin
      if ((pd_up_r | ref_tick) & (pd_dn_r | fp_rise)) begin
        pd_up_r <= 1'b0;
        pd_dn_r <= 1'b0;
      end else begin
        pd_up_r <= pd_up_r | ref_tick;
        pd_dn_r <= pd_dn_r | fp_rise;
      end
      if (pd_up_r | pd_dn_r) begin
        pw_r <= (pw_r == 4'hf) ? pw_r : pw_r + 4'h1;
      end else begin
        pw_r <= 4'h0;
      end
      // In the two minimum-width modes the correction pulse fires every period, locked or not
      if (ref_tick) begin
        corr_r <= min_w;
      end else if (corr_r != 4'h0) begin
        corr_r <= corr_r - 4'h1;
      end
      pump_up_r <= pump_up_nxt;
      pump_dn_r <= pump_dn_nxt;
    end
  end

  // ----------------------------------------------------------------
  // IF counter
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      if_cnt_r  <= {IFW{1'b0}};
      gate_r    <= 32'h00000000;
      if_run_r  <= 1'b0;
      if_done_r <= 1'b0;
    end else if (clk_en) begin
      if (!cte) begin
        if_cnt_r  <= {IFW{1'b0}};
        gate_r    <= 32'h00000000;
        if_run_r  <= 1'b0;
        if_done_r <= 1'b0;
      end else if (!if_run_r && !if_done_r) begin
        if_run_r <= 1'b1;
      end else if (if_run_r) begin
        if (if_rise) begin
          if_cnt_r <= if_cnt_r + {{(IFW-1){1'b0}}, 1'b1};
        end
        if (ifdone_ev) begin
          if_run_r  <= 1'b0;
          if_done_r <= 1'b1;
        end else begin
          gate_r <= gate_r + 32'h00000001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Data-out pin (open drain, oe high pulls low)
  // ----------------------------------------------------------------
  reg do_val;

  always @* begin
    if (ce_s) begin
      do_val = out_sr_r[23];
    end else begin
      case (do_mode)
        `PLLD_DOM_LOCK:   do_val = lock_r;
        `PLLD_DOM_IFDONE: do_val = if_done_r;
        `PLLD_DOM_PORT:   do_val = port_s;
        default:          do_val = 1'b1;
      endcase
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      ser_do_out_r <= 1'b0;
      ser_do_oe_r  <= 1'b0;
    end else if (clk_en) begin
      ser_do_out_r <= 1'b0;
      ser_do_oe_r  <= ~do_val;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts: sticky status, enable, clear
  // ----------------------------------------------------------------
  wire [`PLLD_IRQ_BITS-1:0] irq_set = {xfer_end, ifdone_ev, unlock_ev};
  wire [`PLLD_IRQ_BITS-1:0] irq_clr =
    (wr_go && awaddr_r == `PLLD_ADDR_IRQ_CLR) ? wdata_r[`PLLD_IRQ_BITS-1:0] : 3'h0;

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= 3'h0;
      irq_en_r   <= 3'h0;
      irq_r      <= 1'b0;
    end else if (clk_en) begin
      irq_stat_r <= irq_set | (irq_stat_r & ~irq_clr);
      if (wr_go && awaddr_r == `PLLD_ADDR_IRQ_EN && wstrb_r[0]) begin
        irq_en_r <= wdata_r[`PLLD_IRQ_BITS-1:0];
      end
      irq_r <= |((irq_set | (irq_stat_r & ~irq_clr)) & irq_en_r);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  reg [31:0] rd_val;

  always @* begin
    case (s_axi_araddr)
      `PLLD_ADDR_CFG:      rd_val = {8'h00, cfg_r};
      `PLLD_ADDR_STAT:     rd_val = {29'h0, if_done_r, unlock_flag_r, lock_r};
      `PLLD_ADDR_IFCNT:    rd_val = {{(32-IFW){1'b0}}, if_cnt_r};
      `PLLD_ADDR_IRQ_STAT: rd_val = {29'h0, irq_stat_r};
      `PLLD_ADDR_IRQ_EN:   rd_val = {29'h0, irq_en_r};
      default:             rd_val = 32'h00000000;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'h0;
      s_axi_rdata   <= 32'h00000000;
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h00000000;
      wstrb_r       <= 4'h0;
    end else if (clk_en) begin
      s_axi_awready <= ~aw_got_r & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_got_r & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awaddr_r) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
      end else begin
        s_axi_arready <= ~s_axi_rvalid;
      end
    end
  end

endmodule // plldet_top

//--- pusl_ctrl_model.sv
`timescale 1ns/1ns

// ----------------------------------------------------------------
// Controller on the four-wire serial link
// ----------------------------------------------------------------
module pusl_ctrl_model #(
  parameter int REF_NS = 200
) (
  input  wire do_pin,
  output reg  ser_ce,
  output reg  ser_cl,
  output reg  ser_di
);
  // Idle link: enable and clock stand low
  initial begin
    ser_ce = 1'b0;
    ser_cl = 1'b0;
    ser_di = 1'b0;
  end

  // Wait out the lock evaluation after a divisor or loop change
  task automatic settle();
    #(3 * REF_NS);
  endtask

  // One frame of n bits; clock runs only inside the frame, 125 ns period
  task automatic xfer(input int n, input logic [23:0] w, output logic [23:0] r);
    int i;
    begin
      r = 24'h000000;
      #1;  // Step off the sampling edge of aclk
      ser_ce = 1'b1;
      #125;
      for (i = 0; i < n; i++) begin
        ser_di = w[23 - i];
        #62;
        ser_cl = 1'b1;
        r = {r[22:0], do_pin};
        #63;
        ser_cl = 1'b0;
      end
      #125;
      ser_ce = 1'b0;
      ser_di = ~ser_di;  // Released line shows no stale value
      #250;
    end
  endtask
endmodule // pusl_ctrl_model

//--- pusl_properties.sv
`timescale 1ns/1ns

// ----------------------------------------------------------------
// Port-level checks on the bus slave and the config latch
// ----------------------------------------------------------------
module pusl_properties (
  input wire        aclk,
  input wire        aresetn,
  input wire        ser_ce,
  input wire [15:0] divisor_r,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready
);
  reg       ce_q_r;
  reg [3:0] since_r;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Cycles since the last enable fall or bus write, saturating
  always @(posedge aclk) begin
    ce_q_r <= ser_ce;
    if (!aresetn || (ce_q_r && !ser_ce) || (s_axi_awvalid && s_axi_awready))
      since_r <= 4'h0;
    else if (since_r != 4'hf)
      since_r <= since_r + 4'h1;
  end

  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_write_reopen: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_awready ##1 s_axi_awready) else $error("write address ready timing");
  a_read_reopen: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_arready ##1 s_axi_arready) else $error("read address ready timing");
  a_resp_codes: assert property (s_axi_bvalid |-> !s_axi_bresp[0])
    else $error("illegal write response");
  a_slverr_data: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |->
    s_axi_rdata == 32'h00000000) else $error("refused read carries data");
  a_div_cause: assert property ($changed(divisor_r) |-> since_r <= 4'ha)
    else $error("divisor changed without a latch event");

  // Main scenarios reached
  c_serial_end: cover property (ce_q_r && !ser_ce);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_div_change: cover property ($changed(divisor_r));
endmodule // pusl_properties

bind plldet_top pusl_properties i_pusl_properties (
  .aclk, .aresetn, .ser_ce, .divisor_r, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);
